/* File: hdl/arfc_map.vh */
// Register offsets, field positions, reset values and error codes for the rate and loop block
`ifndef ARFC_MAP_VH
`define ARFC_MAP_VH
`define ARFC_ADDR_W 10
`define ARFC_OFS_RATE2 10'h211
`define ARFC_OFS_RSTAT 10'h212
`define ARFC_OFS_L1EN 10'h220
`define ARFC_OFS_L1DIV 10'h221
`define ARFC_OFS_L1NUM 10'h222
`define ARFC_OFS_L1INT 10'h223
`define ARFC_OFS_L1DEN 10'h226
`define ARFC_OFS_L1EFS 10'h227
`define ARFC_OFS_RATE1 10'h210
`define ARFC_OFS_CFG 10'h2f0
`define ARFC_OFS_IRQ_STAT 10'h2f1
`define ARFC_OFS_IRQ_EN 10'h2f2
`define ARFC_OFS_IRQ_CLR 10'h2f3
`define ARFC_RST_RATE 8'h83
`define ARFC_RST_SR 4'h8
`define ARFC_RST_CR 4'h3
`define ARFC_RST_EFS_RSV 2'h3
`define ARFC_RST_OUTDIV 6'h00
`define ARFC_RST_FRATIO 3'h0
`define ARFC_RST_NUM 16'h0000
`define ARFC_RST_INT 10'h000
`define ARFC_RST_DEN 16'h0000
`define ARFC_RST_EFS 3'h6
`define ARFC_RST_CFG 8'h00
`define ARFC_SR_MAX 4'ha
`define ARFC_SR_88K 4'h9
`define ARFC_CR_MIN 4'h1
`define ARFC_CR_MAX 4'h9
`define ARFC_OUTDIV_MIN 6'h03
`define ARFC_ERR_NONE 4'h0
`define ARFC_ERR_SR 4'h1
`define ARFC_ERR_DIV 4'h2
`define ARFC_ERR_BOTHDIR 4'h3
`define ARFC_ERR_COMBO 4'h4
`define ARFC_ERR_HIRATE 4'h5
`define ARFC_ERR_CORE_SYSTEM_CLOCK 4'h6
`define ARFC_ERR_ASYNC_MIX 4'h7
`define ARFC_ERR_SAME_SR 4'h8
`define ARFC_ERR_SAME_MIX 4'h9
`define ARFC_CFG_ASYNC 0
`define ARFC_CFG_SRC 1
`define ARFC_CFG_ADC1 2
`define ARFC_CFG_DAC1 3
`define ARFC_CFG_ADC2 4
`define ARFC_CFG_DAC2 5
`define ARFC_CFG_DIV1 6
`define ARFC_CFG_DIV2 7
`endif

/* File: hdl/arfc_rate_loop.v */
// Rate selection, rate error status and first loop configuration registers
//
// Implementation choice: the plain strobed port.
`include "arfc_map.vh"
module arfc_rate_loop (
    input wire sys_clk,
    input wire rst_b,
    input wire [9:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    output reg irq,
    output reg [3:0] second_port_sample_rate_sel,
    output reg [3:0] second_port_clock_ratio,
    output reg [3:0] rate_config_error_code,
    output reg loop_enable,
    output reg loop_oscillator_enable,
    output reg [5:0] loop_output_divider,
    output reg [6:0] loop_output_divide_value,
    output reg [2:0] loop_vco_ratio,
    output reg [4:0] loop_vco_divide_value,
    output reg [15:0] loop_fraction_numerator,
    output reg [15:0] loop_fraction_denominator,
    output reg [9:0] loop_integer_multiplier,
    output reg loop_fractional_mode_enable
);
    reg [3:0] first_port_sample_rate_sel_r;
    reg [3:0] first_port_clock_ratio_r;
    reg [7:0] cfg_r;
    reg [1:0] efs_rsv_r;
    reg [1:0] irq_en_r;
    reg [3:0] err_nxt;
    reg [6:0] outdiv_nxt;
    reg [4:0] vco_nxt;
    reg [15:0] rdata_nxt;
    reg loop_enable_d_r;
    reg [3:0] err_d_r;
    // Next values of the software fields
    reg [3:0] sr2_nxt;
    reg [3:0] cr2_nxt;
    reg [3:0] sr1_nxt;
    reg [3:0] cr1_nxt;
    reg loop_en_nxt;
    reg osc_en_nxt;
    reg [5:0] outdiv_code_nxt;
    reg [2:0] fratio_nxt;
    reg [15:0] num_nxt;
    reg [9:0] int_nxt;
    reg [15:0] den_nxt;
    reg efs_nxt;
    reg [1:0] efs_rsv_nxt;
    reg [7:0] cfg_nxt;
    reg [1:0] irq_en_nxt;
    wire [1:0] irq_stat;
    wire [1:0] irq_evt;
    wire [1:0] irq_clr;
    wire wr_rate2 = reg_wr && (reg_addr == `ARFC_OFS_RATE2);
    wire wr_l1en = reg_wr && (reg_addr == `ARFC_OFS_L1EN);
    wire wr_l1div = reg_wr && (reg_addr == `ARFC_OFS_L1DIV);
    wire wr_l1num = reg_wr && (reg_addr == `ARFC_OFS_L1NUM);
    wire wr_l1int = reg_wr && (reg_addr == `ARFC_OFS_L1INT);
    wire wr_l1den = reg_wr && (reg_addr == `ARFC_OFS_L1DEN);
    wire wr_l1efs = reg_wr && (reg_addr == `ARFC_OFS_L1EFS);
    wire wr_rate1 = reg_wr && (reg_addr == `ARFC_OFS_RATE1);
    wire wr_cfg = reg_wr && (reg_addr == `ARFC_OFS_CFG);
    wire wr_ien = reg_wr && (reg_addr == `ARFC_OFS_IRQ_EN);
    wire wr_iclr = reg_wr && (reg_addr == `ARFC_OFS_IRQ_CLR);
    wire p1_bad_rate, p1_bad_ratio, p1_hi, p1_bad_hi, p1_bad_sys;
    wire p2_bad_rate, p2_bad_ratio, p2_hi, p2_bad_hi, p2_bad_sys;

    arfc_ratio_check u_chk1 (
        .sample_rate_sel(first_port_sample_rate_sel_r),
        .clock_ratio(first_port_clock_ratio_r),
        .adc_on(cfg_r[`ARFC_CFG_ADC1]),
        .dac_on(cfg_r[`ARFC_CFG_DAC1]),
        .bad_rate(p1_bad_rate),
        .bad_ratio(p1_bad_ratio),
        .hi_rate(p1_hi),
        .bad_hi_use(p1_bad_hi),
        .bad_core_system_clock(p1_bad_sys)
    );

    arfc_ratio_check u_chk2 (
        .sample_rate_sel(second_port_sample_rate_sel),
        .clock_ratio(second_port_clock_ratio),
        .adc_on(cfg_r[`ARFC_CFG_ADC2]),
        .dac_on(cfg_r[`ARFC_CFG_DAC2]),
        .bad_rate(p2_bad_rate),
        .bad_ratio(p2_bad_ratio),
        .hi_rate(p2_hi),
        .bad_hi_use(p2_bad_hi),
        .bad_core_system_clock(p2_bad_sys)
    );

    wire mix1 = cfg_r[`ARFC_CFG_ADC1] && cfg_r[`ARFC_CFG_DAC1];
    wire mix2 = cfg_r[`ARFC_CFG_ADC2] && cfg_r[`ARFC_CFG_DAC2];
    wire both_dir1 = mix1 && cfg_r[`ARFC_CFG_DIV1];
    wire both_dir2 = mix2 && cfg_r[`ARFC_CFG_DIV2];
    wire sys_mix = cfg_r[`ARFC_CFG_SRC] ? mix2 : mix1;
    wire same_src = !cfg_r[`ARFC_CFG_ASYNC];
    // Conditions for each error code
    wire cond_sr = p1_bad_rate || p2_bad_rate;
    wire cond_div = p1_bad_ratio || p2_bad_ratio;
    wire cond_both = both_dir1 || both_dir2;
    wire cond_combo = (cfg_r[`ARFC_CFG_DIV1] && p1_hi) || (cfg_r[`ARFC_CFG_DIV2] && p2_hi);
    wire cond_hi_use = p1_bad_hi || p2_bad_hi;
    wire cond_sys = p1_bad_sys || p2_bad_sys;
    // Async ports: the core clock port must not carry both directions
    wire cond_async_mix = !same_src && sys_mix;
    wire rates_differ = first_port_sample_rate_sel_r != second_port_sample_rate_sel;
    wire cond_same_sr = same_src && rates_differ && (p1_hi || p2_hi);
    wire cond_same_mix = same_src && mix1 && mix2;

    // Priority: lowest code found first
    always @* begin
        if (cond_sr) begin
            err_nxt = `ARFC_ERR_SR;
        end else if (cond_div) begin
            err_nxt = `ARFC_ERR_DIV;
        end else if (cond_both) begin
            err_nxt = `ARFC_ERR_BOTHDIR;
        end else if (cond_combo) begin
            err_nxt = `ARFC_ERR_COMBO;
        end else if (cond_hi_use) begin
            err_nxt = `ARFC_ERR_HIRATE;
        end else if (cond_sys) begin
            err_nxt = `ARFC_ERR_CORE_SYSTEM_CLOCK;
        end else if (cond_async_mix) begin
            err_nxt = `ARFC_ERR_ASYNC_MIX;
        end else if (cond_same_sr) begin
            err_nxt = `ARFC_ERR_SAME_SR;
        end else if (cond_same_mix) begin
            err_nxt = `ARFC_ERR_SAME_MIX;
        end else begin
            err_nxt = `ARFC_ERR_NONE;
        end
    end

    // Decoded divide values
    always @* begin
        outdiv_nxt = {1'b0, loop_output_divider} + 7'h01;
        if (loop_output_divider < `ARFC_OUTDIV_MIN) begin
            outdiv_nxt = 7'h00;
        end
        case (loop_vco_ratio)
            3'h0: vco_nxt = 5'h01;
            3'h1: vco_nxt = 5'h02;
            3'h2: vco_nxt = 5'h04;
            3'h3: vco_nxt = 5'h08;
            default: vco_nxt = 5'h10;
        endcase
    end

    // Next values of the software fields
    always @* begin
        sr2_nxt = second_port_sample_rate_sel;
        cr2_nxt = second_port_clock_ratio;
        sr1_nxt = first_port_sample_rate_sel_r;
        cr1_nxt = first_port_clock_ratio_r;
        loop_en_nxt = loop_enable;
        osc_en_nxt = loop_oscillator_enable;
        outdiv_code_nxt = loop_output_divider;
        fratio_nxt = loop_vco_ratio;
        num_nxt = loop_fraction_numerator;
        int_nxt = loop_integer_multiplier;
        den_nxt = loop_fraction_denominator;
        efs_nxt = loop_fractional_mode_enable;
        efs_rsv_nxt = efs_rsv_r;
        cfg_nxt = cfg_r;
        irq_en_nxt = irq_en_r;
        if (wr_rate2) begin
            sr2_nxt = reg_wdata[7:4];
            cr2_nxt = reg_wdata[3:0];
        end
        if (wr_rate1) begin
            sr1_nxt = reg_wdata[7:4];
            cr1_nxt = reg_wdata[3:0];
        end
        if (wr_l1en) begin
            osc_en_nxt = reg_wdata[1];
            loop_en_nxt = reg_wdata[0];
        end
        if (wr_l1div) begin
            outdiv_code_nxt = reg_wdata[13:8];
            fratio_nxt = reg_wdata[2:0];
        end
        if (wr_l1num) begin
            num_nxt = reg_wdata;
        end
        if (wr_l1int) begin
            int_nxt = reg_wdata[14:5];
        end
        if (wr_l1den) begin
            den_nxt = reg_wdata;
        end
        if (wr_l1efs) begin
            efs_rsv_nxt = reg_wdata[2:1];
            efs_nxt = reg_wdata[0];
        end
        if (wr_cfg) begin
            cfg_nxt = reg_wdata[7:0];
        end
        if (wr_ien) begin
            irq_en_nxt = reg_wdata[1:0];
        end
    end

    // Register writes; the rate status has no write path
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            second_port_sample_rate_sel <= `ARFC_RST_SR;
            second_port_clock_ratio <= `ARFC_RST_CR;
            first_port_sample_rate_sel_r <= `ARFC_RST_SR;
            first_port_clock_ratio_r <= `ARFC_RST_CR;
            loop_enable <= 1'b0;
            loop_oscillator_enable <= 1'b0;
            loop_output_divider <= `ARFC_RST_OUTDIV;
            loop_vco_ratio <= `ARFC_RST_FRATIO;
            loop_fraction_numerator <= `ARFC_RST_NUM;
            loop_fraction_denominator <= `ARFC_RST_DEN;
            loop_integer_multiplier <= `ARFC_RST_INT;
            loop_fractional_mode_enable <= 1'b0;
            efs_rsv_r <= `ARFC_RST_EFS_RSV;
            cfg_r <= `ARFC_RST_CFG;
            irq_en_r <= 2'h0;
        end else begin
            second_port_sample_rate_sel <= sr2_nxt;
            second_port_clock_ratio <= cr2_nxt;
            first_port_sample_rate_sel_r <= sr1_nxt;
            first_port_clock_ratio_r <= cr1_nxt;
            loop_enable <= loop_en_nxt;
            loop_oscillator_enable <= osc_en_nxt;
            loop_output_divider <= outdiv_code_nxt;
            loop_vco_ratio <= fratio_nxt;
            loop_fraction_numerator <= num_nxt;
            loop_fraction_denominator <= den_nxt;
            loop_integer_multiplier <= int_nxt;
            loop_fractional_mode_enable <= efs_nxt;
            efs_rsv_r <= efs_rsv_nxt;
            cfg_r <= cfg_nxt;
            irq_en_r <= irq_en_nxt;
        end
    end

    // Derived state and error status
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rate_config_error_code <= `ARFC_ERR_NONE;
            err_d_r <= `ARFC_ERR_NONE;
            loop_enable_d_r <= 1'b0;
            loop_output_divide_value <= 7'h00;
            loop_vco_divide_value <= 5'h01;
        end else begin
            rate_config_error_code <= err_nxt;
            err_d_r <= rate_config_error_code;
            loop_enable_d_r <= loop_enable;
            loop_output_divide_value <= outdiv_nxt;
            loop_vco_divide_value <= vco_nxt;
        end
    end

    // Events: bit0 new error code, bit1 loop enabled
    assign irq_evt[0] = (rate_config_error_code != err_d_r) &&
                        (rate_config_error_code != `ARFC_ERR_NONE);
    assign irq_evt[1] = loop_enable && !loop_enable_d_r;
    assign irq_clr = wr_iclr ? reg_wdata[1:0] : 2'h0;

    arfc_status_reg #(
        .W(2)
    ) u_stat (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .event_in(irq_evt),
        .clear_in(irq_clr),
        .status_r(irq_stat)
    );

    // Read values, laid out as in the registers
    wire [15:0] rd_rate2 = {8'h00, second_port_sample_rate_sel, second_port_clock_ratio};
    wire [15:0] rd_rate1 = {8'h00, first_port_sample_rate_sel_r, first_port_clock_ratio_r};
    wire [15:0] rd_rstat = {12'h000, rate_config_error_code};
    wire [15:0] rd_l1en = {14'h0000, loop_oscillator_enable, loop_enable};
    wire [15:0] rd_l1div = {2'h0, loop_output_divider, 5'h00, loop_vco_ratio};
    wire [15:0] rd_l1int = {1'b0, loop_integer_multiplier, 5'h00};
    wire [15:0] rd_l1efs = {13'h0000, efs_rsv_r, loop_fractional_mode_enable};
    wire [15:0] rd_cfg = {8'h00, cfg_r};
    wire [15:0] rd_istat = {14'h0000, irq_stat};
    wire [15:0] rd_ien = {14'h0000, irq_en_r};

    // Read mux
    always @* begin
        case (reg_addr)
            `ARFC_OFS_RATE2: rdata_nxt = rd_rate2;
            `ARFC_OFS_RATE1: rdata_nxt = rd_rate1;
            `ARFC_OFS_RSTAT: rdata_nxt = rd_rstat;
            `ARFC_OFS_L1EN: rdata_nxt = rd_l1en;
            `ARFC_OFS_L1DIV: rdata_nxt = rd_l1div;
            `ARFC_OFS_L1NUM: rdata_nxt = loop_fraction_numerator;
            `ARFC_OFS_L1INT: rdata_nxt = rd_l1int;
            `ARFC_OFS_L1DEN: rdata_nxt = loop_fraction_denominator;
            `ARFC_OFS_L1EFS: rdata_nxt = rd_l1efs;
            `ARFC_OFS_CFG: rdata_nxt = rd_cfg;
            `ARFC_OFS_IRQ_STAT: rdata_nxt = rd_istat;
            `ARFC_OFS_IRQ_EN: rdata_nxt = rd_ien;
            default: rdata_nxt = 16'h0000;
        endcase
    end

    // Read data stands the cycle after each cycle of reg_rd, zero otherwise
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_rd ? rdata_nxt : 16'h0000;
        end
    end

    // Level interrupt from enabled sticky status
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_en_r);
        end
    end
endmodule

/* File: hdl/arfc_ratio_check.v */
// Checks one interface rate and clock ratio pair for range faults
`include "arfc_map.vh"
module arfc_ratio_check (
    input wire [3:0] sample_rate_sel,
    input wire [3:0] clock_ratio,
    input wire adc_on,
    input wire dac_on,
    output wire bad_rate,
    output wire bad_ratio,
    output wire hi_rate,
    output wire bad_hi_use,
    output wire bad_core_system_clock
);
    assign bad_rate = sample_rate_sel > `ARFC_SR_MAX;
    assign bad_ratio = (clock_ratio < `ARFC_CR_MIN) || (clock_ratio > `ARFC_CR_MAX);
    assign hi_rate = (sample_rate_sel == `ARFC_SR_88K) || (sample_rate_sel == `ARFC_SR_MAX);
    // High rates carry playback only
    assign bad_hi_use = hi_rate && adc_on;
    // Ratios below 256 give too slow a core clock at low rates
    assign bad_core_system_clock = !bad_ratio && (clock_ratio < 4'h3) && !hi_rate;
endmodule

/* File: hdl/arfc_status_reg.v */
// Sticky status bits with write-one clear; the enable mask is applied outside this module
module arfc_status_reg #(
    parameter W = 2
) (
    input wire sys_clk,
    input wire rst_b,
    input wire [W-1:0] event_in,
    input wire [W-1:0] clear_in,
    output reg [W-1:0] status_r
);
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_r <= {W{1'b0}};
        end else begin
            status_r <= (status_r & ~clear_in) | event_in;
        end
    end
endmodule

/* File: test/arfc_rate_loop_bench.sv */
// Register level test of the rate and loop block
module arfc_rate_loop_bench;
    timeunit 1ns;
    timeprecision 1ps;
    reg sys_clk;
    reg rst_b;
    reg [9:0] reg_addr;
    reg [15:0] reg_wdata;
    reg reg_wr;
    reg reg_rd;
    wire [15:0] reg_rdata;
    wire irq;
    wire [3:0] err_code;
    wire [6:0] div_val;
    wire [4:0] vco_val;
    wire [9:0] int_mul;
    wire lp_en;
    wire osc_en;
    wire frac_en;
    wire [15:0] den;
    reg [15:0] rdv;
    reg [9:0] adr [0:6];
    reg [15:0] msk [0:6];
    integer num_errors;
    integer n_tests;
    integer cyc;
    integer i;
    arfc_rate_loop dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .second_port_sample_rate_sel(), .second_port_clock_ratio(),
        .rate_config_error_code(err_code), .loop_enable(lp_en), .loop_oscillator_enable(osc_en),
        .loop_output_divider(), .loop_output_divide_value(div_val), .loop_vco_ratio(),
        .loop_vco_divide_value(vco_val), .loop_fraction_numerator(),
        .loop_fraction_denominator(den), .loop_integer_multiplier(int_mul),
        .loop_fractional_mode_enable(frac_en));
    task wr(input [9:0] a, input [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task rdchk(input [9:0] a, input [15:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        rdv = reg_rdata;
        chk(rdv, exp);
    endtask
    task errc(input [15:0] cfg, input [15:0] rate, input [3:0] exp);
        wr(10'h2f0, cfg);
        wr(10'h211, rate);
        repeat (4) @(posedge sys_clk);
        chk({12'h000, err_code}, {12'h000, exp});
    endtask
    task test_done;
        $display("Errors %0d of %0d checks", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            num_errors = num_errors + 1;
            test_done;
        end
    end
    initial begin
        rst_b = 1'b0;
        reg_addr = 10'h000;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        num_errors = 0;
        n_tests = 0;
        cyc = 0;
        adr[0] = 10'h211; msk[0] = 16'h00ff;
        adr[1] = 10'h221; msk[1] = 16'h3f07;
        adr[2] = 10'h222; msk[2] = 16'hffff;
        adr[3] = 10'h223; msk[3] = 16'h7fe0;
        adr[4] = 10'h226; msk[4] = 16'hffff;
        adr[5] = 10'h227; msk[5] = 16'h0007;
        adr[6] = 10'h220; msk[6] = 16'h0003;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        rdchk(10'h211, 16'h0083);
        rdchk(10'h212, 16'h0000);
        rdchk(10'h220, 16'h0000);
        rdchk(10'h221, 16'h0000);
        rdchk(10'h222, 16'h0000);
        rdchk(10'h226, 16'h0000);
        rdchk(10'h227, 16'h0006);
        // Loop enable written last; fractional mode set by its own enable bit at 10'h227
        for (i = 0; i < 7; i = i + 1) begin
            wr(adr[i], 16'hffff);
            rdchk(adr[i], msk[i]);
        end
        rdchk(10'h2f1, 16'h0003);
        chk({14'h0000, osc_en, lp_en}, 16'h0003);
        chk(den, 16'hffff);
        chk({15'h0000, frac_en}, 16'h0001);
        wr(10'h220, 16'h0000);
        chk({9'h000, div_val}, 16'h0040);
        chk({6'h00, int_mul}, 16'h03ff);
        for (i = 0; i < 8; i = i + 1) begin
            wr(10'h221, 16'((i << 8) | i));
            repeat (2) @(posedge sys_clk);
            chk({9'h000, div_val}, 16'(i < 3 ? 0 : i + 1));
            chk({11'h000, vco_val}, 16'(i > 3 ? 16 : 1 << i));
        end
        wr(10'h211, 16'h0083);
        wr(10'h2f3, 16'h0003);
        wr(10'h2f2, 16'h0001);
        errc(16'h0000, 16'h00b3, 4'h1);
        chk({15'h0000, irq}, 16'h0001);
        rdchk(10'h212, 16'h0001);
        wr(10'h212, 16'h000f);
        rdchk(10'h212, 16'h0001);
        wr(10'h2f3, 16'h0001);
        repeat (3) @(posedge sys_clk);
        chk({15'h0000, irq}, 16'h0000);
        wr(10'h2f2, 16'h0000);
        errc(16'h0000, 16'h0080, 4'h2);
        errc(16'h0090, 16'h00a3, 4'h4);
        errc(16'h0010, 16'h00a3, 4'h5);
        errc(16'h0000, 16'h0081, 4'h6);
        errc(16'h0000, 16'h0093, 4'h8);
        errc(16'h003c, 16'h0083, 4'h9);
        errc(16'h004c, 16'h0083, 4'h3);
        errc(16'h000d, 16'h0083, 4'h7);
        errc(16'h0021, 16'h00a3, 4'h0);
        errc(16'h0000, 16'h0083, 4'h0);
        rdchk(10'h2f1, 16'h0001);
        chk({15'h0000, irq}, 16'h0000);
        rdchk(10'h300, 16'h0000);
        test_done;
    end
endmodule

/* File: test/arfc_rate_loop_sva.sv */
// Concurrent checks on the rate and loop register block ports
module arfc_rate_loop_sva (
    input wire sys_clk,
    input wire rst_b,
    input wire [9:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire [3:0] second_port_sample_rate_sel,
    input wire [3:0] second_port_clock_ratio,
    input wire [3:0] rate_config_error_code,
    input wire [5:0] loop_output_divider,
    input wire [6:0] loop_output_divide_value,
    input wire [2:0] loop_vco_ratio,
    input wire [4:0] loop_vco_divide_value,
    input wire [15:0] loop_fraction_numerator,
    input wire [9:0] loop_integer_multiplier
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    property p_rate;
        reg_wr && reg_addr == 10'h211 |=> second_port_sample_rate_sel == $past(reg_wdata[7:4]);
    endproperty
    a_rate: assert property (p_rate) else $error("rate field not loaded");
    property p_ratio;
        reg_wr && reg_addr == 10'h211 |=> second_port_clock_ratio == $past(reg_wdata[3:0]);
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio field not loaded");
    property p_err_rd;
        reg_rd && reg_addr == 10'h212 |=> reg_rdata == {12'h000, $past(rate_config_error_code)};
    endproperty
    a_err_rd: assert property (p_err_rd) else $error("status read mismatch");
    property p_bad_sr;
        second_port_sample_rate_sel > 4'ha |=> rate_config_error_code == 4'h1;
    endproperty
    a_bad_sr: assert property (p_bad_sr) else $error("bad rate not flagged");
    property p_outdiv;
        1'b1 |=> loop_output_divide_value == ($past(loop_output_divider) < 6'h03 ? 7'h00 :
            {1'b0, $past(loop_output_divider)} + 7'h01);
    endproperty
    a_outdiv: assert property (p_outdiv) else $error("output divide wrong");
    property p_vco;
        1'b1 |=> loop_vco_divide_value == ($past(loop_vco_ratio[2]) ? 5'h10 :
            5'h01 << $past(loop_vco_ratio[1:0]));
    endproperty
    a_vco: assert property (p_vco) else $error("vco divide wrong");
    property p_num;
        reg_wr && reg_addr == 10'h222 |=> loop_fraction_numerator == $past(reg_wdata);
    endproperty
    a_num: assert property (p_num) else $error("numerator not loaded");
    property p_int;
        reg_wr && reg_addr == 10'h223 |=> loop_integer_multiplier == $past(reg_wdata[14:5]);
    endproperty
    a_int: assert property (p_int) else $error("multiplier not loaded");
endmodule

bind arfc_rate_loop arfc_rate_loop_sva chk_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .second_port_sample_rate_sel(second_port_sample_rate_sel),
    .second_port_clock_ratio(second_port_clock_ratio),
    .rate_config_error_code(rate_config_error_code), .loop_output_divider(loop_output_divider),
    .loop_output_divide_value(loop_output_divide_value), .loop_vco_ratio(loop_vco_ratio),
    .loop_vco_divide_value(loop_vco_divide_value),
    .loop_fraction_numerator(loop_fraction_numerator),
    .loop_integer_multiplier(loop_integer_multiplier));
